/* hw/cdbs_debounce.sv */
`timescale 1ns/10ps
`include "cdbs_defs.svh"

module cdbs_debounce
    import cdbs_pkg::*;
#(
    parameter logic [`CDBS_CNT_W-1:0] DB_TICKS = `CDBS_DEF_DB_TICKS
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic dbclk_valid,
    input wire logic db_tick,
    input wire logic card_detect_pin_n,
    output logic card_present,
    output logic card_stable
);

    cdbs_det_t st_r; // registered state
    cdbs_det_t st_nxt; // next state
    logic changed; // pin differs from last sample

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        changed = card_detect_pin_n != st_r.pin_q;
        st_nxt.pin_q = card_detect_pin_n;
        case (st_r.state)
            CDBS_RESET: begin
                // wait for the debounce clock to run
                if (dbclk_valid) begin
                    st_nxt.state = CDBS_DEBOUNCING;
                    st_nxt.cnt = '0;
                end
            end
            CDBS_DEBOUNCING: begin
                // any edge restarts the stable period
                if (changed) begin
                    st_nxt.cnt = '0;
                end else if (db_tick) begin
                    if (st_r.cnt == DB_TICKS - `CDBS_CNT_ONE) begin
                        st_nxt.cnt = '0;
                        // low pin means a card sits in the socket
                        st_nxt.state = card_detect_pin_n ? CDBS_NO_CARD
                                                         : CDBS_INSERTED;
                    end else begin
                        st_nxt.cnt = st_r.cnt + `CDBS_CNT_ONE;
                    end
                end
            end
            CDBS_INSERTED: begin
                // removal is reported at once, no settling
                if (card_detect_pin_n) begin
                    st_nxt.state = CDBS_DEBOUNCING;
                    st_nxt.cnt = '0;
                end
            end
            CDBS_NO_CARD: begin
                // an edge means something moved in the socket
                if (changed) begin
                    st_nxt.state = CDBS_DEBOUNCING;
                    st_nxt.cnt = '0;
                end
            end
            default: begin
                st_nxt.state = CDBS_RESET;
            end
        endcase
        // present only in the inserted state
        st_nxt.present = st_nxt.state == CDBS_INSERTED;
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign card_present = st_r.present;
    assign card_stable = st_r.state[1];

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_settled;
        st_r.state == CDBS_DEBOUNCING && db_tick &&
            card_detect_pin_n == st_r.pin_q &&
            st_r.cnt == DB_TICKS - `CDBS_CNT_ONE;
    endsequence

    property p_leave_reset;
        @(posedge core_clk) disable iff (!resetn)
        (st_r.state == CDBS_RESET && dbclk_valid) |=>
            st_r.state == CDBS_DEBOUNCING;
    endproperty
    a_leave_reset: assert property (p_leave_reset)
        else $error("reset state not left with valid clock");

    property p_settle;
        @(posedge core_clk) disable iff (!resetn)
        s_settled |=> (st_r.state == (st_r.pin_q ? CDBS_NO_CARD
                                                 : CDBS_INSERTED));
    endproperty
    a_settle: assert property (p_settle)
        else $error("stable pin did not settle the state");

    property p_remove;
        @(posedge core_clk) disable iff (!resetn)
        (st_r.state == CDBS_INSERTED && card_detect_pin_n) |=>
            (st_r.state == CDBS_DEBOUNCING && !card_present);
    endproperty
    a_remove: assert property (p_remove)
        else $error("removal did not return to debouncing");

    property p_present;
        @(posedge core_clk) disable iff (!resetn)
        card_present |-> st_r.state == CDBS_INSERTED;
    endproperty
    a_present: assert property (p_present)
        else $error("card present outside inserted state");

endmodule

/* hw/cdbs_defs.svh */
`ifndef CDBS_DEFS_SVH
`define CDBS_DEFS_SVH

// ****************************************************************
// register offsets (byte addresses on the plain register port)
// ****************************************************************
`define CDBS_OFF_PRESENT 8'h00
`define CDBS_OFF_INT_STAT 8'h04
`define CDBS_OFF_INT_CLR 8'h08
`define CDBS_OFF_INT_EN 8'h0c
`define CDBS_OFF_GAP_CTRL 8'h10

// ****************************************************************
// present state field positions
// ****************************************************************
`define CDBS_PS_RD_ACTIVE 9
`define CDBS_PS_WR_SPACE 10
`define CDBS_PS_RD_AVAIL 11
`define CDBS_PS_INSERTED 16
`define CDBS_PS_STABLE 17
`define CDBS_PS_PIN_LVL 18

// gap control: write 1 to resume a paused read
`define CDBS_GAP_RESUME 0

// ****************************************************************
// interrupt status / clear / enable layout
// ****************************************************************
`define CDBS_INT_W 5
`define CDBS_INT_INSERT 0
`define CDBS_INT_REMOVE 1
`define CDBS_INT_RD_READY 2
`define CDBS_INT_WR_READY 3
`define CDBS_INT_XFER_DONE 4

// ****************************************************************
// counters and default counts
// ****************************************************************
`define CDBS_CNT_W 16
`define CDBS_CNT_ONE 16'h0001
`define CDBS_DEF_BLK_WORDS 16'h0080
`define CDBS_DEF_DB_TICKS 16'h0010

`endif

/* hw/cdbs_pkg.sv */
package cdbs_pkg;
`include "cdbs_defs.svh"

    // ************************************************************
    // card detect states
    // ************************************************************
    typedef enum logic [1:0] {
        CDBS_RESET = 2'b00,
        CDBS_DEBOUNCING = 2'b01,
        CDBS_INSERTED = 2'b10,
        CDBS_NO_CARD = 2'b11
    } cdbs_det_state_t;

    // state of the debounce machine
    typedef struct packed {
        cdbs_det_state_t state;
        logic [`CDBS_CNT_W-1:0] cnt;
        logic pin_q;
        logic present;
    } cdbs_det_t;

    // state of the status register bank
    typedef struct packed {
        logic rd_avail;
        logic [`CDBS_CNT_W-1:0] rd_cnt;
        logic wr_space;
        logic [`CDBS_CNT_W-1:0] wr_cnt;
        logic wr_locked;
        logic rd_active;
        logic [`CDBS_INT_W-1:0] ist;
        logic [`CDBS_INT_W-1:0] ien;
        logic ins_q;
        logic resume;
        logic irq;
        logic [31:0] rdata;
    } cdbs_bank_t;

endpackage

/* hw/cdbs_top.sv */
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "cdbs_defs.svh"

// Behaviour
// - leave reset once debounce clock valid
// - stable pin for period settles state
// - removal while inserted returns to debouncing
// - bit 11 shows readable block data
// - read data rise raises read-ready event
// - read data falls after block read
// - bit 10 shows write space available
// - write space rise raises write-ready event
// - write space falls after block written
// - no write space after final block
// - read command end sets read active
// - status bits 9-11 are read only
// - resume after gap sets read active
// - descriptor mode ends read by table
// - presence edges raise insert/remove events
module cdbs_top
    import cdbs_pkg::*;
#(
    parameter logic [`CDBS_CNT_W-1:0] DB_TICKS = `CDBS_DEF_DB_TICKS,
    parameter logic [`CDBS_CNT_W-1:0] BLK_WORDS = `CDBS_DEF_BLK_WORDS
) (
    input wire logic core_clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    output logic irq,
    // card socket and debounce timing
    input wire logic card_detect_pin_n,
    input wire logic dbclk_valid,
    input wire logic db_tick,
    output logic card_present,
    // transfer engine side
    input wire logic xfer_start,
    input wire logic rd_cmd_end,
    input wire logic rd_block_ready,
    input wire logic buf_rd_pop,
    input wire logic rd_xfer_done,
    input wire logic descriptor_dma_mode,
    input wire logic desc_end,
    input wire logic wr_space_ready,
    input wire logic buf_wr_push,
    input wire logic wr_last_block,
    output logic gap_resume
);

    cdbs_bank_t st_r; // registered bank state
    cdbs_bank_t st_nxt; // next bank state
    logic card_stable; // detect machine settled
    logic [`CDBS_INT_W-1:0] ev; // events of this cycle
    logic [`CDBS_INT_W-1:0] clr; // software clear mask
    logic rd_last; // final word of a read block
    logic wr_last; // final word of a write block
    logic res_wr; // software resume strobe
    logic rd_end; // read transfer finishes

    // ************************************************************
    // card detect debounce
    // ************************************************************
    cdbs_debounce #(
        .DB_TICKS(DB_TICKS)
    ) u_debounce (
        .core_clk(core_clk),
        .resetn(resetn),
        .dbclk_valid(dbclk_valid),
        .db_tick(db_tick),
        .card_detect_pin_n(card_detect_pin_n),
        .card_present(card_present),
        .card_stable(card_stable)
    );

    // ************************************************************
    // read multiplexer
    // ************************************************************
    // bits not listed stay zero, reserved 12-15 among them
    function automatic logic [31:0] rd_mux(
        input logic [7:0] a,
        input cdbs_bank_t s,
        input logic present,
        input logic stable,
        input logic pin_n
    );
        logic [31:0] v;
        v = '0;
        case (a)
            `CDBS_OFF_PRESENT: begin
                v[`CDBS_PS_RD_ACTIVE] = s.rd_active;
                v[`CDBS_PS_WR_SPACE] = s.wr_space;
                v[`CDBS_PS_RD_AVAIL] = s.rd_avail;
                v[`CDBS_PS_INSERTED] = present;
                v[`CDBS_PS_STABLE] = stable;
                // raw pin, not debounced, for testing only
                v[`CDBS_PS_PIN_LVL] = !pin_n;
            end
            `CDBS_OFF_INT_STAT: begin
                v[`CDBS_INT_W-1:0] = s.ist;
            end
            `CDBS_OFF_INT_EN: begin
                v[`CDBS_INT_W-1:0] = s.ien;
            end
            default: begin
                // clear, gap control and unmapped read zero
                v = '0;
            end
        endcase
        return v;
    endfunction

    // ************************************************************
    // next state of the bank
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        ev = '0;
        clr = '0;
        st_nxt.rdata = '0;
        st_nxt.resume = 1'b0;
        rd_last = st_r.rd_cnt == BLK_WORDS - `CDBS_CNT_ONE;
        wr_last = st_r.wr_cnt == BLK_WORDS - `CDBS_CNT_ONE;
        res_wr = wr_en && addr == `CDBS_OFF_GAP_CTRL &&
                 wdata[`CDBS_GAP_RESUME];
        // end of read: table end in descriptor mode, else count
        rd_end = descriptor_dma_mode ? desc_end : rd_xfer_done;

        // presence edges
        st_nxt.ins_q = card_present;
        ev[`CDBS_INT_INSERT] = card_present && !st_r.ins_q;
        ev[`CDBS_INT_REMOVE] = !card_present && st_r.ins_q;

        // read buffer: one block held at a time; a ready pulse
        // while a block is still unread is not queued
        if (st_r.rd_avail) begin
            if (buf_rd_pop) begin
                if (rd_last) begin
                    st_nxt.rd_avail = 1'b0;
                    st_nxt.rd_cnt = '0;
                end else begin
                    st_nxt.rd_cnt = st_r.rd_cnt + `CDBS_CNT_ONE;
                end
            end
        end else if (rd_block_ready) begin
            st_nxt.rd_avail = 1'b1;
            st_nxt.rd_cnt = '0;
            ev[`CDBS_INT_RD_READY] = 1'b1;
        end

        // a new transfer releases the final-block lock
        if (xfer_start) begin
            st_nxt.wr_locked = 1'b0;
        end

        // write buffer space
        if (st_r.wr_space) begin
            if (buf_wr_push) begin
                if (wr_last) begin
                    st_nxt.wr_space = 1'b0;
                    st_nxt.wr_cnt = '0;
                    // final block written: stay closed
                    if (wr_last_block) begin
                        st_nxt.wr_locked = 1'b1;
                    end
                end else begin
                    st_nxt.wr_cnt = st_r.wr_cnt + `CDBS_CNT_ONE;
                end
            end
        end else if (wr_space_ready && !st_r.wr_locked) begin
            st_nxt.wr_space = 1'b1;
            st_nxt.wr_cnt = '0;
            ev[`CDBS_INT_WR_READY] = 1'b1;
        end

        // read transfer active: a set beats an end in one cycle
        if (rd_cmd_end) begin
            st_nxt.rd_active = 1'b1;
        end else if (res_wr) begin
            st_nxt.rd_active = 1'b1;
        end else if (rd_end && st_r.rd_active) begin
            st_nxt.rd_active = 1'b0;
            ev[`CDBS_INT_XFER_DONE] = 1'b1;
        end

        // register writes; status bits take no software write
        if (wr_en) begin
            case (addr)
                `CDBS_OFF_INT_CLR: begin
                    clr = wdata[`CDBS_INT_W-1:0];
                end
                `CDBS_OFF_INT_EN: begin
                    st_nxt.ien = wdata[`CDBS_INT_W-1:0];
                end
                `CDBS_OFF_GAP_CTRL: begin
                    st_nxt.resume = wdata[`CDBS_GAP_RESUME];
                end
                default: begin
                    // present state and unmapped: ignored
                    clr = '0;
                end
            endcase
        end

        // sticky status, a new event wins over its clear
        st_nxt.ist = (st_r.ist & ~clr) | ev;
        st_nxt.irq = |(st_nxt.ist & st_nxt.ien);

        // read data stand in the cycle after the strobe only
        if (rd_en) begin
            st_nxt.rdata = rd_mux(addr, st_r, card_present,
                                  card_stable, card_detect_pin_n);
        end
    end

    // ************************************************************
    // bank register
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign irq = st_r.irq;
    assign gap_resume = st_r.resume;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_res_write;
        wr_en && addr == `CDBS_OFF_GAP_CTRL && wdata[`CDBS_GAP_RESUME];
    endsequence

    sequence s_rd_drain;
        st_r.rd_avail && buf_rd_pop &&
            st_r.rd_cnt == BLK_WORDS - `CDBS_CNT_ONE;
    endsequence

    property p_rd_avail_irq;
        @(posedge core_clk) disable iff (!resetn)
        $rose(st_r.rd_avail) |-> st_r.ist[`CDBS_INT_RD_READY];
    endproperty
    a_rd_avail_irq: assert property (p_rd_avail_irq)
        else $error("read ready event missing on rise");

    property p_rd_drain;
        @(posedge core_clk) disable iff (!resetn)
        s_rd_drain |=> !st_r.rd_avail;
    endproperty
    a_rd_drain: assert property (p_rd_drain)
        else $error("read flag stayed after block drained");

    property p_wr_space_irq;
        @(posedge core_clk) disable iff (!resetn)
        $rose(st_r.wr_space) |-> st_r.ist[`CDBS_INT_WR_READY];
    endproperty
    a_wr_space_irq: assert property (p_wr_space_irq)
        else $error("write ready event missing on rise");

    property p_wr_locked;
        @(posedge core_clk) disable iff (!resetn)
        (st_r.wr_locked && !xfer_start) |=> !$rose(st_r.wr_space);
    endproperty
    a_wr_locked: assert property (p_wr_locked)
        else $error("write space reopened after final block");

    property p_rd_start;
        @(posedge core_clk) disable iff (!resetn)
        rd_cmd_end |=> st_r.rd_active [*1];
    endproperty
    a_rd_start: assert property (p_rd_start)
        else $error("read active not set after command end");

    property p_resume;
        @(posedge core_clk) disable iff (!resetn)
        s_res_write |=> (st_r.rd_active && gap_resume);
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume did not set read active");

    property p_desc_end;
        @(posedge core_clk) disable iff (!resetn)
        (descriptor_dma_mode && rd_xfer_done && !desc_end &&
            st_r.rd_active) |=> st_r.rd_active;
    endproperty
    a_desc_end: assert property (p_desc_end)
        else $error("block count ended a descriptor mode read");

    property p_insert_irq;
        @(posedge core_clk) disable iff (!resetn)
        $rose(card_present) |=> st_r.ist[`CDBS_INT_INSERT];
    endproperty
    a_insert_irq: assert property (p_insert_irq)
        else $error("insertion event missing");

    property p_reserved;
        @(posedge core_clk) disable iff (!resetn)
        rd_en |=> rdata[15:12] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bits not zero");

    property p_ro_status;
        @(posedge core_clk) disable iff (!resetn)
        (wr_en && addr == `CDBS_OFF_PRESENT && !rd_cmd_end &&
            !rd_end && !buf_rd_pop && !rd_block_ready &&
            !buf_wr_push && !wr_space_ready) |=>
            $stable(st_r.rd_active) && $stable(st_r.rd_avail) &&
            $stable(st_r.wr_space);
    endproperty
    a_ro_status: assert property (p_ro_status)
        else $error("software write changed a status bit");

endmodule

/* verification/cdbs_socket_model.sv */
`timescale 1ns/10ps

// ****************************************************************
// card socket and debounce timebase
// ****************************************************************
module cdbs_socket_model #(
    parameter int TICK_DIV = 3
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic insert,
    output logic card_detect_pin_n,
    output logic dbclk_valid,
    output logic db_tick
);
    int div; // slow timebase divider

    // the pin has a pull-up, so an empty socket reads high; the
    // timebase only starts after reset so the detect logic waits
    always @(posedge core_clk) begin
        card_detect_pin_n <= ~insert;
        if (!resetn) begin
            div <= 0;
            dbclk_valid <= 1'b0;
            db_tick <= 1'b0;
        end else begin
            dbclk_valid <= 1'b1;
            div <= (div == TICK_DIV - 1) ? 0 : div + 1;
            db_tick <= dbclk_valid && (div == 0);
        end
    end
endmodule

/* verification/test_card_detect_buffer_status.sv */
`timescale 1ns/10ps

module test_card_detect_buffer_status;
    import cdbs_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic card_present;
    logic gap_resume;
    logic pin_n;
    logic dbv;
    logic tick;
    logic insert = 1'b0;
    logic dma_mode = 1'b0; // descriptor mode level
    logic last_blk = 1'b0; // final write block level
    // pulses: 0 start,1 cmd end,2 rd ready,3 pop,4 rd done,
    // 5 desc end,6 wr ready,7 push
    logic [7:0] ev = 8'h00;
    int err_total = 0;
    int n_checks = 0;

    always #5 core_clk = ~core_clk;

    cdbs_socket_model u_sock (.core_clk(core_clk), .resetn(resetn),
        .insert(insert), .card_detect_pin_n(pin_n),
        .dbclk_valid(dbv), .db_tick(tick));

    // small counts keep debounce and blocks short
    cdbs_top #(.DB_TICKS(16'h0002), .BLK_WORDS(16'h0002)) u_dut (
        .core_clk(core_clk), .resetn(resetn), .addr(addr),
        .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .irq(irq), .card_detect_pin_n(pin_n), .dbclk_valid(dbv),
        .db_tick(tick), .card_present(card_present),
        .xfer_start(ev[0]), .rd_cmd_end(ev[1]),
        .rd_block_ready(ev[2]), .buf_rd_pop(ev[3]),
        .rd_xfer_done(ev[4]), .descriptor_dma_mode(dma_mode),
        .desc_end(ev[5]), .wr_space_ready(ev[6]),
        .buf_wr_push(ev[7]), .wr_last_block(last_blk),
        .gap_resume(gap_resume));

    // ************************************************************
    // shared helpers
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] m, input logic [31:0] e);
        @(posedge core_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge core_clk);
        rd_en <= 1'b0;
        #1 chk(nm, e, rdata & m);
    endtask

    task automatic pulse(input logic [7:0] m);
        @(posedge core_clk);
        ev <= m;
        @(posedge core_clk);
        ev <= 8'h00;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_detect();
        int n;
        chk("present_rst", 32'h0, {31'h0, card_present});
        repeat (40) @(posedge core_clk);
        rd_chk("no_card", 8'h00, 32'hffffffff, 32'h00020000);
        reg_wr(8'h0c, 32'h1f);
        rd_chk("int_en", 8'h0c, 32'hffffffff, 32'h1f);
        insert <= 1'b1;
        n = 0;
        while (card_present !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1 n++;
        end
        chk("present", 32'h1, {31'h0, card_present});
        rd_chk("ins", 8'h00, 32'h0007fe00, 32'h00070000);
        rd_chk("ins_int", 8'h04, 32'hffffffff, 32'h1);
        chk("irq_on", 32'h1, {31'h0, irq});
        reg_wr(8'h08, 32'h1f);
        #1 chk("irq_off", 32'h0, {31'h0, irq});
        @(posedge core_clk);
        insert <= 1'b0;
        // sampled removal must drop presence without settling
        repeat (3) @(posedge core_clk);
        #1 chk("removed", 32'h0, {31'h0, card_present});
        rd_chk("rem_int", 8'h04, 32'hffffffff, 32'h2);
        reg_wr(8'h08, 32'h1f);
    endtask

    task automatic t_read_buf();
        pulse(8'h04);
        rd_chk("rd_av", 8'h00, 32'h0e00, 32'h0800);
        rd_chk("rd_int", 8'h04, 32'hffffffff, 32'h4);
        pulse(8'h04);
        pulse(8'h08);
        rd_chk("rd_av1", 8'h00, 32'h0e00, 32'h0800);
        pulse(8'h08);
        rd_chk("rd_av0", 8'h00, 32'h0e00, 32'h0);
        reg_wr(8'h08, 32'h1f);
    endtask

    task automatic t_write_buf();
        pulse(8'h40);
        rd_chk("wr_sp", 8'h00, 32'h0e00, 32'h0400);
        rd_chk("wr_int", 8'h04, 32'hffffffff, 32'h8);
        reg_wr(8'h08, 32'h1f);
        pulse(8'h80);
        pulse(8'h80);
        last_blk <= 1'b1;
        rd_chk("wr_sp0", 8'h00, 32'h0e00, 32'h0);
        pulse(8'h40);
        pulse(8'h80);
        pulse(8'h80);
        reg_wr(8'h08, 32'h1f);
        pulse(8'h40);
        last_blk <= 1'b0;
        rd_chk("lock_sp", 8'h00, 32'h0e00, 32'h0);
        rd_chk("lock_int", 8'h04, 32'hffffffff, 32'h0);
        pulse(8'h01);
        pulse(8'h40);
        rd_chk("unlock", 8'h00, 32'h0e00, 32'h0400);
        pulse(8'h80);
        pulse(8'h80);
        reg_wr(8'h08, 32'h1f);
    endtask

    task automatic t_rd_active();
        pulse(8'h02);
        rd_chk("ra_set", 8'h00, 32'h0e00, 32'h0200);
        pulse(8'h10);
        rd_chk("ra_clr", 8'h00, 32'h0e00, 32'h0);
        rd_chk("done_int", 8'h04, 32'hffffffff, 32'h10);
        reg_wr(8'h10, 32'h1);
        dma_mode <= 1'b1;
        #1 chk("resume", 32'h1, {31'h0, gap_resume});
        rd_chk("ra_res", 8'h00, 32'h0e00, 32'h0200);
        pulse(8'h10);
        rd_chk("ra_desc", 8'h00, 32'h0e00, 32'h0200);
        pulse(8'h20);
        dma_mode <= 1'b0;
        rd_chk("ra_dend", 8'h00, 32'h0e00, 32'h0);
        reg_wr(8'h08, 32'h1f);
    endtask

    // status words ignore writes; reserved and unmapped read zero
    task automatic t_read_only();
        repeat (30) @(posedge core_clk);
        reg_wr(8'h00, 32'hffffffff);
        rd_chk("ps_ro", 8'h00, 32'hffffffff, 32'h00020000);
        reg_wr(8'h04, 32'h1f);
        rd_chk("ist_ro", 8'h04, 32'hffffffff, 32'h0);
        rd_chk("unmapped", 8'h20, 32'hffffffff, 32'h0);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_detect();
        t_read_buf();
        t_write_buf();
        t_rd_active();
        t_read_only();
        wrap_up();
    end
endmodule
